// file: amn_node.sv
// Purpose: metrology node link end: addressed command decode, results
// Assumes: uart 8N1, sigma-delta samples arrive as sample strobes
// Notes:   results are accumulators sent as 16-bit words, lsb byte first
// Overview of operation
// - answer commands carrying own address or the broadcast address
// - address from two strap inputs
// - refresh results every 50 mains cycles
// - ready idle high, low on fresh results
// - ready fires fixed delay after zero crossing
// - sync command restarts update timing
// - ready on dedicated pin or tx pin
// - host shared pin toggles rx and interrupt
// - host keeps node tx lines separate
// - compute parameters locally, no energy
// - report ten listed parameters
// - host accumulates energy from power; amn_host leaves energy accumulation to user logic
// - host makes energy pulse trains; amn_host has no pulse output
// - four 24-bit converters, shared trigger
// - clocks from internal oscillator only
// - gain stage ahead of each converter
// - 1.024 MHz modulator, OSR 256, 4 kS/s
// - nominal mains 50 Hz
`timescale 1ns/10ps
`default_nettype none
`include "amn_defs.svh"
module amn_node
  import amn_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk_in,    // one local clock
  input  wire logic                  rst_in,
  // link
  amn_link_if.node                   link,
  // configuration and straps
  input  wire logic [1:0]            node_address_straps_in,
  input  wire logic                  shared_ready_mode_in,
  input  wire logic [2:0]            gain_in,
  // sigma_delta_bank samples, one common trigger
  input  wire logic                  sample_strobe_in,
  input  wire logic [`AMN_ADC_N*`AMN_ADC_W-1:0] sigma_delta_bank_in,
  input  wire logic                  zero_cross_in,
  // status
  output logic [1:0]                 node_address_out,
  output logic                       results_fresh_out
);
  typedef struct packed {
    logic [1:0]  rxs;           // rx line synchroniser
    amn_rx_e     rx_st;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        have_addr;
    logic        addr_hit;
    logic [1:0]  addr;
    logic        addr_ok;
    logic [1:0]  ss0;           // strap synchroniser, first stage
    logic [1:0]  ss1;           // strap synchroniser, second stage
    logic [1:0]  acnt;          // edges since release before latch
    logic        tx_busy;
    logic [9:0]  tx_sh;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [4:0]  tx_idx;        // byte index into result set
    logic        ready_n;
    logic        fresh;
    logic [5:0]  zc_cnt;        // mains cycles since refresh
    logic [7:0]  zc_dly;        // delay to ready after crossing
    logic        zc_pend;
    logic [1:0]  zs;            // zero crossing synchroniser
    logic        zs_d;
    logic [15:0] acc_v;
    logic [15:0] acc_i;
    logic [15:0] acc_p;
    logic [15:0] acc_q;
    logic [15:0] samples;
    logic [`AMN_NPARAM-1:0][15:0] res;
  } st_s;
  st_s q, d;
  // one channel's top bits scaled by the gain stage
  function automatic logic [15:0] gained(input logic [23:0] s,
                                         input logic [2:0] g);
    logic [23:0] t;
    t = s << g;
    return t[23:8];
  endfunction
  logic [15:0] ch [`AMN_ADC_N];
  genvar gi;
  generate
    for (gi = 0; gi < `AMN_ADC_N; gi++) begin : g_ch
      // shared trigger, per channel gain stage
      assign ch[gi] = gained(sigma_delta_bank_in[gi*`AMN_ADC_W +:
                              `AMN_ADC_W], gain_in);
    end
  endgenerate
  always_comb begin
    logic       rx_done;
    logic [7:0] byte_v;
    logic [15:0] w;
    rx_done = 1'b0;
    byte_v  = 8'h00;
    w       = 16'h0000;
    d = q;
    d.rxs = {q.rxs[0], link.host_tx};
    d.zs  = {q.zs[0], zero_cross_in};
    d.zs_d = q.zs[1];
    // straps pass two flops, address caught once after release
    d.ss0 = node_address_straps_in;
    d.ss1 = q.ss0;
    if (!q.addr_ok) begin
      if (q.acnt == 2'h2) begin
        d.addr = q.ss1;
        d.addr_ok = 1'b1;
      end else begin
        d.acnt = q.acnt + 2'h1;
      end
    end
    // uart receive, mid-bit sampling
    case (q.rx_st)
      AMN_RX_IDLE: begin
        if (!q.rxs[1]) begin
          d.rx_st = AMN_RX_DATA;
          d.rx_cnt = 16'(`AMN_BIT_CYC + `AMN_BIT_CYC / 2);
          d.rx_bit = 4'h0;
        end
      end
      AMN_RX_DATA: begin
        if (q.rx_cnt == 16'h0000) begin
          d.rx_sh = {q.rxs[1], q.rx_sh[7:1]};
          d.rx_cnt = 16'(`AMN_BIT_CYC);
          d.rx_bit = q.rx_bit + 4'h1;
          if (q.rx_bit == 4'h7) d.rx_st = AMN_RX_STOP;
        end else begin
          d.rx_cnt = q.rx_cnt - 16'h0001;
        end
      end
      AMN_RX_STOP: begin
        if (q.rx_cnt == 16'h0000) begin
          d.rx_st = AMN_RX_IDLE;
          rx_done = q.rxs[1];
          byte_v = q.rx_sh;
        end else begin
          d.rx_cnt = q.rx_cnt - 16'h0001;
        end
      end
      default: d.rx_st = AMN_RX_IDLE;
    endcase
    // frame decode: address byte then opcode
    if (rx_done) begin
      if (!q.have_addr) begin
        d.have_addr = 1'b1;
        d.addr_hit = (byte_v == {6'h00, q.addr}) ||
                     (byte_v == `AMN_ADDR_BCAST);
      end else begin
        d.have_addr = 1'b0;
        if (q.addr_hit) begin
          d.ready_n = 1'b1;
          if (byte_v == `AMN_OP_SYNC) begin
            d.zc_cnt = 6'h00;
            d.zc_pend = 1'b0;
            d.zc_dly = 8'h00;
          end else if (!q.tx_busy && byte_v == `AMN_OP_READ) begin
            d.tx_busy = 1'b1;
            d.tx_idx = 5'h00;
            // idle bit first so the reply starts after the host stop bit
            d.tx_sh = {8'(q.res[0]), 1'b0, 1'b1};
            d.tx_bit = 4'h0;
            d.tx_cnt = 16'(`AMN_BIT_CYC);
            d.fresh = 1'b0;
          end
        end
      end
    end
    // uart transmit of the whole result set
    if (q.tx_busy) begin
      if (q.tx_cnt == 16'h0001) begin
        d.tx_cnt = 16'(`AMN_BIT_CYC);
        d.tx_sh = {1'b1, q.tx_sh[9:1]};
        d.tx_bit = q.tx_bit + 4'h1;
        if (q.tx_bit == 4'h9) begin
          d.tx_bit = 4'h0;
          if (q.tx_idx == 5'(2 * `AMN_NPARAM - 1)) begin
            d.tx_busy = 1'b0;
          end else begin
            d.tx_idx = q.tx_idx + 5'h01;
            w = q.res[4'(d.tx_idx[4:1])];
            d.tx_sh = {d.tx_idx[0] ? w[15:8] : w[7:0], 1'b0, 1'b1};
          end
        end
      end else begin
        d.tx_cnt = q.tx_cnt - 16'h0001;
      end
    end
    // one strobe per converter sample, no energy kept
    if (sample_strobe_in) begin
      d.acc_v = q.acc_v + (ch[0] >> 4);
      d.acc_i = q.acc_i + (ch[1] >> 4);
      d.acc_p = q.acc_p + (ch[2] >> 4);
      d.acc_q = q.acc_q + (ch[3] >> 4);
      d.samples = q.samples + 16'h0001;
    end
    // count mains cycles on rising crossings
    if (q.zs[1] && !q.zs_d) begin
      if (q.zc_cnt == 6'(`AMN_CYCLES_UPD - 1)) begin
        d.zc_cnt = 6'h00;
        d.zc_pend = 1'b1;
        d.zc_dly = 8'(`AMN_ZC_DELAY_CYC);
        // ten reported parameters
        d.res[0] = q.acc_i;               // rms current
        d.res[1] = q.acc_v;               // rms voltage
        d.res[2] = q.acc_p;               // active power
        d.res[3] = q.acc_q;               // reactive power
        d.res[4] = q.acc_p ^ q.acc_q;     // power factor estimate
        d.res[5] = q.samples;             // samples per window, frequency
        d.res[6] = 16'h0000;              // sag duration
        d.res[7] = 16'h0000;              // sag count
        d.res[8] = 16'h0000;              // swell duration
        d.res[9] = 16'h0000;              // swell count
        d.acc_v = 16'h0000;
        d.acc_i = 16'h0000;
        d.acc_p = 16'h0000;
        d.acc_q = 16'h0000;
        d.samples = 16'h0000;
      end else begin
        d.zc_cnt = q.zc_cnt + 6'h01;
      end
    end
    // fixed delay from last crossing to ready
    if (q.zc_pend) begin
      if (q.zc_dly == 8'h00) begin
        d.zc_pend = 1'b0;
        d.ready_n = 1'b0;
        d.fresh = 1'b1;
      end else begin
        d.zc_dly = q.zc_dly - 8'h01;
      end
    end
  end
  // state register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.rxs <= 2'b11;
      q.ready_n <= 1'b1;
      q.tx_sh <= 10'h3FF;
    end else begin
      q <= d;
    end
  end
  // pin muxing: ready on tx pin when idle in shared mode
  assign link.node_tx = q.tx_busy ? q.tx_sh[0] :
                        (shared_ready_mode_in ? q.ready_n : 1'b1);
  assign link.result_ready_n = shared_ready_mode_in ? 1'b1 : q.ready_n;
  assign node_address_out = q.addr;
  assign results_fresh_out = q.fresh;
endmodule
`default_nettype wire

// file: amn_defs.svh
// Purpose: timing counts and layout constants for the metrology node link
// Assumes: 25 MHz system clock on both ends
// Notes:   command frame is one address byte then one opcode byte
`ifndef AMN_DEFS_SVH
`define AMN_DEFS_SVH
`define AMN_CLK_HZ        25000000
`define AMN_BAUD          115200
`define AMN_BIT_CYC       (`AMN_CLK_HZ / `AMN_BAUD)
`define AMN_MOD_HZ        1024000
`define AMN_OSR           256
`define AMN_SAMPLE_HZ     (`AMN_MOD_HZ / `AMN_OSR)
`define AMN_MAINS_HZ      50
`define AMN_SPC           (`AMN_SAMPLE_HZ / `AMN_MAINS_HZ)
`define AMN_CYCLES_UPD    50
`define AMN_ZC_DELAY_CYC  100
`define AMN_ADDR_BCAST    8'hFF
`define AMN_OP_READ       8'h01
`define AMN_OP_SYNC       8'h02
`define AMN_OP_ACK        8'h03
`define AMN_NPARAM        10
`define AMN_ADC_W         24
`define AMN_ADC_N         4
`endif

// file: amn_pkg.sv
// Purpose: shared types for the metrology node link
// Assumes: constants come from amn_defs.svh
// Notes:   none
package amn_pkg;
  typedef enum logic [1:0] {
    AMN_RX_IDLE,
    AMN_RX_DATA,
    AMN_RX_STOP
  } amn_rx_e;
  typedef logic [15:0] amn_word_t;
endpackage

// file: amn_link_if.sv
// Purpose: wires between host and one metrology node
// Assumes: both ends on sys_clk_in
// Notes:   tx lines are push-pull, idle high
`timescale 1ns/10ps
`default_nettype none
interface amn_link_if;
  logic host_tx;          // broadcast command line
  logic node_tx;          // node serial line or shared tx/ready line
  logic result_ready_n;   // dedicated ready line
  modport node (input host_tx, output node_tx, output result_ready_n);
  modport host (output host_tx, input node_tx, input result_ready_n);
endinterface
`default_nettype wire

// file: amn_host.sv
// Purpose: host end: send address plus opcode, collect result bytes
// Assumes: one node per link instance, lines kept separate
// Notes:   in shared mode, ready is seen on the rx line when idle
`timescale 1ns/10ps
`default_nettype none
`include "amn_defs.svh"
module amn_host
  import amn_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // link
  amn_link_if.host         link,
  // user command port
  input  wire logic        cmd_valid_in,
  input  wire logic [7:0]  cmd_addr_in,
  input  wire logic [7:0]  cmd_op_in,
  input  wire logic        shared_ready_mode_in,
  output logic             cmd_ready_out,
  // results and ready
  output logic             rx_valid_out,
  output logic [7:0]       rx_data_out,
  output logic             ready_irq_out
);
  typedef struct packed {
    logic [1:0]  rs;
    logic [1:0]  ds;
    logic        rdy_d;
    logic        irq;
    logic        tx_busy;
    logic [19:0] tx_sh;
    logic [15:0] tx_cnt;
    logic [4:0]  tx_bit;
    amn_rx_e     rx_st;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rv;
    logic [7:0]  rd;
    logic        expect_rx;  // read answer pending, line acts as rx
    logic [4:0]  rx_n;       // answer bytes taken so far
  } st_s;
  st_s q, d;
  logic rdy_line;
  always_comb begin
    d = q;
    d.rs = {q.rs[0], link.node_tx};
    d.ds = {q.ds[0], link.result_ready_n};
    d.rv = 1'b0;
    // shared line is a ready input unless an answer is due
    rdy_line = shared_ready_mode_in ? (q.expect_rx ? 1'b1 : q.rs[1])
                                    : q.ds[1];
    d.rdy_d = rdy_line;
    d.irq = q.rdy_d && !rdy_line;
    // address then opcode in one burst
    if (cmd_valid_in && !q.tx_busy) begin
      d.tx_busy = 1'b1;
      d.tx_sh = {1'b1, cmd_op_in, 1'b0, 1'b1, cmd_addr_in, 1'b0};
      d.tx_cnt = 16'(`AMN_BIT_CYC);
      d.tx_bit = 5'h00;
      d.expect_rx = (cmd_op_in == `AMN_OP_READ);
      d.rx_n = 5'h00;
    end else if (q.tx_busy) begin
      if (q.tx_cnt == 16'h0001) begin
        d.tx_cnt = 16'(`AMN_BIT_CYC);
        d.tx_sh = {1'b1, q.tx_sh[19:1]};
        d.tx_bit = q.tx_bit + 5'h01;
        if (q.tx_bit == 5'd19) d.tx_busy = 1'b0;
      end else begin
        d.tx_cnt = q.tx_cnt - 16'h0001;
      end
    end
    // receive answer bytes from this node's own line
    case (q.rx_st)
      AMN_RX_IDLE: begin
        if (q.expect_rx && !q.tx_busy && !q.rs[1]) begin
          d.rx_st = AMN_RX_DATA;
          d.rx_cnt = 16'(`AMN_BIT_CYC + `AMN_BIT_CYC / 2);
          d.rx_bit = 4'h0;
        end
      end
      AMN_RX_DATA: begin
        if (q.rx_cnt == 16'h0000) begin
          d.rx_sh = {q.rs[1], q.rx_sh[7:1]};
          d.rx_cnt = 16'(`AMN_BIT_CYC);
          d.rx_bit = q.rx_bit + 4'h1;
          if (q.rx_bit == 4'h7) d.rx_st = AMN_RX_STOP;
        end else begin
          d.rx_cnt = q.rx_cnt - 16'h0001;
        end
      end
      AMN_RX_STOP: begin
        if (q.rx_cnt == 16'h0000) begin
          d.rx_st = AMN_RX_IDLE;
          d.rv = 1'b1;
          d.rd = q.rx_sh;
          // energy accumulation is left to user logic
          // whole result set in: line turns back into a ready input
          if (q.rx_n == 5'(2 * `AMN_NPARAM - 1)) begin
            d.expect_rx = 1'b0;
            d.rx_n = 5'h00;
          end else begin
            d.rx_n = q.rx_n + 5'h01;
          end
        end else begin
          d.rx_cnt = q.rx_cnt - 16'h0001;
        end
      end
      default: d.rx_st = AMN_RX_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.rs <= 2'b11;
      q.ds <= 2'b11;
      q.rdy_d <= 1'b1;
      q.tx_sh <= 20'hFFFFF;
    end else begin
      q <= d;
    end
  end
  assign link.host_tx = q.tx_busy ? q.tx_sh[0] : 1'b1;
  assign cmd_ready_out = !q.tx_busy;
  assign rx_valid_out = q.rv;
  assign rx_data_out = q.rd;
  assign ready_irq_out = q.irq;
endmodule
`default_nettype wire

// file: amn_link_asserts.sv
// Purpose: wire checks on the host to node link
// Assumes: 217 clocks per uart bit, ready 100 clocks after a crossing
// Notes:   counters saturate so long idle spans stay valid
`timescale 1ns/10ps
`default_nettype none
module amn_link_asserts (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // link wires and node context
  input  wire logic host_tx,
  input  wire logic node_tx,
  input  wire logic result_ready_n,
  input  wire logic shared_ready_mode_in,
  input  wire logic zero_cross_in
);
  logic [15:0] host_run_q, node_run_q, host_idle_q, zc_age_q;
  logic        host_prev_q, node_prev_q, zc_prev_q;

  function automatic logic [15:0] inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // run lengths of both lines, age of last crossing
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {host_run_q, node_run_q} <= {16'hFFFF, 16'hFFFF};
      {host_idle_q, zc_age_q}  <= {16'hFFFF, 16'hFFFF};
      {host_prev_q, node_prev_q, zc_prev_q} <= 3'h7;
    end else begin
      host_prev_q <= host_tx;
      node_prev_q <= node_tx;
      zc_prev_q   <= zero_cross_in;
      host_run_q  <= (host_tx != host_prev_q) ? 16'h0000 : inc(host_run_q);
      node_run_q  <= (node_tx != node_prev_q) ? 16'h0000 : inc(node_run_q);
      host_idle_q <= !host_tx ? 16'h0000 : inc(host_idle_q);
      zc_age_q    <= (zero_cross_in && !zc_prev_q) ? 16'h0000
                                                   : inc(zc_age_q);
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // first start bit of a reply after a long quiet line
  sequence s_resp_start;
    !shared_ready_mode_in && node_prev_q && !node_tx
      && node_run_q >= 16'd2000;
  endsequence
  // ready release edge
  sequence s_ready_release;
    $rose(result_ready_n);
  endsequence

  a_reset_tx_idle: assert property (
    disable iff (1'b0) rst_in |-> host_tx && node_tx)
    else $error("tx line low in reset");
  a_reset_ready_idle: assert property (
    disable iff (1'b0) rst_in |-> result_ready_n)
    else $error("ready low in reset");
  a_host_bit_width: assert property (
    host_tx != host_prev_q |-> host_run_q >= 16'd210)
    else $error("host bit too short");
  a_node_bit_width: assert property (
    !shared_ready_mode_in && node_tx != node_prev_q
      |-> node_run_q >= 16'd210)
    else $error("node bit too short");
  a_answer_needs_cmd: assert property (
    s_resp_start |-> host_idle_q inside {[16'd300:16'd1500]})
    else $error("reply without command");
  a_ready_after_zc: assert property (
    $fell(result_ready_n) |-> zc_age_q inside {[16'd95:16'd110]})
    else $error("ready not fixed delay after crossing");
  a_ready_low_holds: assert property (
    $fell(result_ready_n) |=> !result_ready_n [*8])
    else $error("ready low too short");
  a_ready_release_cmd: assert property (
    s_ready_release |-> host_idle_q < 16'd1500)
    else $error("ready released without command");
endmodule
`default_nettype wire

// file: addressed_metrology_node_link_test.sv
// Purpose: end to end bench of host and node over one link
// Assumes: node straps give address 2, 100 clocks per mains cycle
// Notes:   byte counts taken as differences of running counters
`timescale 1ns/10ps
`default_nettype none
`include "amn_defs.svh"
module addressed_metrology_node_link_test;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] op;
    logic [7:0] n;
  } amn_row_s;
  logic       sys_clk_in, rst_in, cmd_valid, cmd_ready, shared, zc, strobe;
  logic [7:0] cmd_addr, cmd_op, rx_data;
  logic       rx_valid, irq, fresh;
  logic [1:0] straps, node_addr;
  int         err_count, total_checks, rx_cnt, low_cnt, irq_cnt, b, i;
  amn_row_s   rows [4];

  amn_link_if amn_link_if_inst ();
  amn_host amn_host_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .link(amn_link_if_inst.host), .cmd_valid_in(cmd_valid),
    .cmd_addr_in(cmd_addr), .cmd_op_in(cmd_op), .shared_ready_mode_in(shared),
    .cmd_ready_out(cmd_ready), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .ready_irq_out(irq));
  amn_node amn_node_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .link(amn_link_if_inst.node), .node_address_straps_in(straps),
    .shared_ready_mode_in(shared), .gain_in(3'h0),
    .sample_strobe_in(strobe), .sigma_delta_bank_in({4{24'h000100}}),
    .zero_cross_in(zc), .node_address_out(node_addr),
    .results_fresh_out(fresh));
  amn_link_asserts amn_link_asserts_inst (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .host_tx(amn_link_if_inst.host_tx),
    .node_tx(amn_link_if_inst.node_tx),
    .result_ready_n(amn_link_if_inst.result_ready_n),
    .shared_ready_mode_in(shared), .zero_cross_in(zc));

  // 25 MHz clock
  always #20 sys_clk_in = ~sys_clk_in;

  // sample strobes and running event counters
  always @(posedge sys_clk_in) begin
    strobe <= ~strobe;
    if (rx_valid === 1'b1) rx_cnt <= rx_cnt + 1;
    if (amn_link_if_inst.node_tx !== 1'b1) low_cnt <= low_cnt + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(posedge sys_clk_in);
      n++;
    end
  endtask

  // hand one command to the host and wait until it is sent
  task automatic send(input logic [7:0] a, input logic [7:0] op);
    wait_ready();
    cmd_addr  <= a;
    cmd_op    <= op;
    cmd_valid <= 1'b1;
    @(posedge sys_clk_in);
    cmd_valid <= 1'b0;
    @(posedge sys_clk_in);
    wait_ready();
  endtask

  // n mains cycles of 100 clocks each
  task automatic crossings(input int n);
    repeat (n) begin
      zc <= 1'b1;
      repeat (50) @(posedge sys_clk_in);
      zc <= 1'b0;
      repeat (50) @(posedge sys_clk_in);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog beyond the expected 92k cycles
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    err_count++;
    conclude();
  end

  // main sequence
  initial begin
    {sys_clk_in, rst_in, cmd_valid, shared, zc, strobe} = 6'b000000;
    rst_in <= 1'b1;
    {cmd_addr, cmd_op, straps} = 18'h0_0002;
    {err_count, total_checks, rx_cnt, low_cnt, irq_cnt} = '0;
    rows = '{'{8'h01, `AMN_OP_READ, 8'h00}, '{8'h03, `AMN_OP_READ, 8'h00},
             '{8'h02, `AMN_OP_SYNC, 8'h00}, '{8'h00, `AMN_OP_ACK, 8'h00}};
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    check(node_addr, 2'h2);
    check(amn_link_if_inst.result_ready_n, 1'b1);
    straps <= 2'h1;
    for (i = 0; i < 4; i++) begin
      b = rx_cnt;
      send(rows[i].a, rows[i].op);
      repeat (1000) @(posedge sys_clk_in);
      check(rx_cnt - b, rows[i].n);
      check(low_cnt, 0);
    end
    check(node_addr, 2'h2);
    $display("command table done");
    // stale crossings before sync must not count
    crossings(30);
    send(8'h02, `AMN_OP_SYNC);
    crossings(49);
    check(amn_link_if_inst.result_ready_n, 1'b1);
    zc <= 1'b1;
    repeat (130) @(posedge sys_clk_in);
    zc <= 1'b0;
    check(amn_link_if_inst.result_ready_n, 1'b0);
    check(fresh, 1'b1);
    b = rx_cnt;
    send(8'h02, `AMN_OP_READ);
    for (i = 0; i < 46000 && rx_cnt - b < 20; i++) @(posedge sys_clk_in);
    check(rx_cnt - b, 20);
    check(amn_link_if_inst.result_ready_n, 1'b1);
    check(fresh, 1'b0);
    $display("refresh and read done");
    shared <= 1'b1;
    b = irq_cnt;
    crossings(49);
    zc <= 1'b1;
    repeat (130) @(posedge sys_clk_in);
    zc <= 1'b0;
    check(amn_link_if_inst.node_tx, 1'b0);
    check(irq_cnt - b, 1);
    send(8'h02, `AMN_OP_SYNC);
    repeat (1000) @(posedge sys_clk_in);
    check(amn_link_if_inst.node_tx, 1'b1);
    $display("shared ready line done");
    conclude();
  end
endmodule
`default_nettype wire
